// ==== unt_assertions.sv ====
// port-level assertions for the serial transceiver top
`timescale 1ns/100ps
`default_nettype none
module unt_assertions
    import unt_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // power and pins
    input wire logic        light_stop_i,
    input wire logic        deep_stop_i,
    input wire logic        wake_o,
    input wire logic        irq_o,
    input wire logic        tx_pin_o,
    input wire logic        tx_pin_oe_o,
    input wire logic        rx_pin_used_o
);
    logic loop_w;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || deep_stop_i);
    sequence apb_setup; psel_i && !penable_i; endsequence
    sequence apb_done; psel_i && penable_i && pready_o; endsequence
    // last committed loop_select; writes during light stop are dropped
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || deep_stop_i)
            loop_w <= 1'b0;
        else if (psel_i && penable_i && pready_o && pwrite_i && !light_stop_i && paddr_i == OFS_CTRL_ONE)
            loop_w <= pwdata_i[C1_LOOP];
    end
    ready_setup_a: assert property (apb_setup |=> pready_o)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    err_addr_a: assert property (apb_done ##0 pslverr_o |-> paddr_i > OFS_STATE || paddr_i[1:0] != 2'b00)
        else $error("error on mapped address");
    err_data_a: assert property (apb_done ##0 pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("error read not zero");
    rx_release_a: assert property (!rx_pin_used_o |-> loop_w || $past(loop_w))
        else $error("rx pin released without loop");
    wake_cause_a: assert property (wake_o |-> $past(light_stop_i) && irq_o)
        else $error("wake without light stop");
    deep_clear_a: assert property (disable iff (sys_rst_i) deep_stop_i |=>
        !pready_o && !irq_o && !wake_o && tx_pin_o && !tx_pin_oe_o && rx_pin_used_o)
        else $error("deep stop did not clear");
    light_hold_a: assert property (light_stop_i [*3] |-> $stable(tx_pin_o) && $stable(tx_pin_oe_o))
        else $error("pins moved in light stop");
endmodule : unt_assertions
bind unt_top unt_assertions unt_assertions_inst (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .light_stop_i, .deep_stop_i, .wake_o, .irq_o, .tx_pin_o,
    .tx_pin_oe_o, .rx_pin_used_o);
`default_nettype wire

// ==== unt_pkg.sv ====
// shared constants, register map and field layouts of the serial transceiver
package unt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
    localparam logic [7:0] OFS_DATA       = 8'h08;
    localparam logic [7:0] OFS_BAUD       = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_MASK       = 8'h14;
    localparam logic [7:0] OFS_STATE      = 8'h18;

    // serial_control_one field positions
    localparam int C1_NINE_BIT   = 0;
    localparam int C1_LOOP       = 1;
    localparam int C1_RX_SRC     = 2;
    localparam int C1_ADDR_WAKE  = 3;
    localparam int C1_TX_ENABLE  = 4;
    localparam int C1_RX_ENABLE  = 5;
    localparam int C1_RX_SLEEP   = 6;
    localparam int C1_WIDTH      = 7;

    // serial_control_three field positions
    localparam int C3_TX_NINTH   = 0;
    localparam int C3_RX_NINTH   = 1;
    localparam int C3_TX_DIR     = 2;

    // status and mask bit positions
    localparam int ST_TX_DONE    = 0;
    localparam int ST_RX_FULL    = 1;
    localparam int ST_RX_EDGE    = 2;
    localparam int ST_OVERRUN    = 3;
    localparam int ST_FRAMING    = 4;
    localparam int ST_WIDTH      = 5;

    // reset values
    localparam logic [C1_WIDTH-1:0] CTRL_ONE_RST = 7'h00;
    localparam logic [15:0]         BAUD_RST     = 16'h0000;
    localparam logic [ST_WIDTH-1:0] MASK_RST     = 5'h00;

    // oversampling: last tick of a bit and the mid point of the start bit
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_MID  = 4'h7;

    typedef struct packed {
        logic rx_sleep;
        logic rx_enable;
        logic tx_enable;
        logic addr_wake;
        logic rx_source_select;
        logic loop_select;
        logic nine_bit_select;
    } unt_ctrl_one_type;

    // one character handed from the buffer to the shifter
    typedef struct packed {
        logic       nine;
        logic [8:0] bits;
    } unt_char_type;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } unt_rx_state_type;
endpackage : unt_pkg

// ==== unt_remote.sv ====
// remote serial device: lsb first, one start and one stop bit, idle high
`timescale 1ns/100ps
`default_nettype none
module unt_remote #(
    parameter int BIT_CLKS = 16
) (
    // clock and line
    input  wire logic clk_i,
    input  wire logic line_i,
    output var logic  line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [8:0] v, input int nb);
        for (int i = -1; i <= nb; i++) begin
            line_o <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : v[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    endtask : send
    // bounded wait for a start bit, then mid-bit sampling; a used-up wait shows in lost
    task automatic get(output logic [8:0] v, input int nb, output bit lost);
        int n;
        v = 9'h000;
        n = 0;
        while (line_i !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        lost = (n >= 4000);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            v[i] = line_i;
        end
    endtask : get
endmodule : unt_remote
`default_nettype wire

// ==== unt_top.sv ====
// serial transceiver with ninth bit, stop modes, loop-back and single-wire modes
`timescale 1ns/100ps
`default_nettype none
module unt_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // power states
    input  wire logic        light_stop_i,
    input  wire logic        deep_stop_i,
    output logic             wake_o,
    output logic             irq_o,
    // serial pins
    input  wire logic        tx_pin_i,
    input  wire logic        rx_pin_i,
    output logic             tx_pin_o,
    output logic             tx_pin_oe_o,
    output logic             rx_pin_used_o
);
    import unt_pkg::*;

    // deep_stop loses everything, so it acts as a reset
    logic rst;
    logic run;
    assign rst = sys_rst_i || deep_stop_i;
    assign run = !light_stop_i && !deep_stop_i;

    // control and status state
    unt_ctrl_one_type      c1_reg, c1_next;
    logic                  tx_ninth_reg, tx_ninth_next;
    logic                  tx_dir_reg, tx_dir_next;
    logic [15:0]           baud_reg, baud_next;
    logic [ST_WIDTH-1:0]   st_reg, st_next;
    logic [ST_WIDTH-1:0]   mask_reg, mask_next;
    logic [7:0]            txb_reg, txb_next;
    logic                  txb_full_reg, txb_full_next;
    logic [31:0]           rdata_reg, rdata_next;
    logic                  ready_reg, ready_next;
    logic                  err_reg, err_next;
    logic                  irq_reg, irq_next;
    logic                  wake_reg, wake_next;

    // receiver state
    unt_rx_state_type      rs_reg, rs_next;
    logic [3:0]            ros_reg, ros_next;
    logic [3:0]            rbit_reg, rbit_next;
    logic [8:0]            rsh_reg, rsh_next;
    logic [7:0]            rxd_reg, rxd_next;
    logic                  rx_ninth_reg, rx_ninth_next;
    logic                  rprev_reg, rprev_next;

    // pin state
    logic                  txo_reg, txo_next;
    logic                  txoe_reg, txoe_next;
    logic                  rxused_reg, rxused_next;

    logic                  tick;
    logic                  tx_line;
    logic                  tx_busy;
    logic                  tx_busy_d_reg;
    logic                  tx_start;
    logic                  rx_in;
    logic                  rx_edge;
    logic                  rx_done;
    logic                  rx_frame_ok;
    logic                  acc;
    logic                  wr;
    logic                  rd_data;
    unt_char_type          tx_char;

    // word read back at a given offset; unmapped reads as zero
    function automatic logic [31:0] reg_view(input logic [7:0] a);
        reg_view = 32'h0000_0000;
        case (a)
            OFS_CTRL_ONE:   reg_view[C1_WIDTH-1:0] = c1_reg;
            OFS_CTRL_THREE: reg_view[2:0] = {tx_dir_reg, rx_ninth_reg, tx_ninth_reg};
            OFS_DATA:       reg_view[7:0] = rxd_reg;
            OFS_BAUD:       reg_view[15:0] = baud_reg;
            OFS_STATUS:     reg_view[ST_WIDTH-1:0] = st_reg;
            OFS_MASK:       reg_view[ST_WIDTH-1:0] = mask_reg;
            OFS_STATE:      reg_view[3:0] = {rx_in, rs_reg != RX_IDLE, tx_busy, txb_full_reg};
            default:        reg_view = 32'h0000_0000;
        endcase
    endfunction : reg_view

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_CTRL_ONE) || (a == OFS_CTRL_THREE) || (a == OFS_DATA) ||
                    (a == OFS_BAUD) || (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_STATE);
    endfunction : is_mapped

    // the ninth bit is taken from the field at the moment of the move
    assign tx_start      = run && c1_reg.tx_enable && txb_full_reg && !tx_busy;
    assign tx_char.nine  = c1_reg.nine_bit_select;
    assign tx_char.bits  = {tx_ninth_reg, txb_reg};

    unt_tx unt_tx_inst (
        .clk_i     (clk_i),
        .sys_rst_i (rst),
        .run_i     (run),
        .divisor_i (baud_reg),
        .start_i   (tx_start),
        .char_i    (tx_char),
        .tick_o    (tick),
        .line_o    (tx_line),
        .busy_o    (tx_busy)
    );

    // receiver source selection
    always_comb begin
        if (!c1_reg.loop_select) begin
            rx_in = rx_pin_i;
        end else if (!c1_reg.rx_source_select) begin
            rx_in = tx_line;
        end else begin
            // echo of own output when driving, line level when listening
            rx_in = tx_dir_reg ? tx_line : tx_pin_i;
        end
    end

    // falling edge from idle; only with the receiver enabled
    assign rx_edge = c1_reg.rx_enable && rprev_reg && !rx_in;

    // apb: setup cycle loads the answer, access phase completes in its first cycle
    assign acc     = psel_i && penable_i && ready_reg;
    assign wr      = acc && pwrite_i && !err_reg && run;
    assign rd_data = acc && !pwrite_i && (paddr_i == OFS_DATA) && run;

    always_comb begin
        c1_next       = c1_reg;
        tx_ninth_next = tx_ninth_reg;
        tx_dir_next   = tx_dir_reg;
        baud_next     = baud_reg;
        st_next       = st_reg;
        mask_next     = mask_reg;
        txb_next      = txb_reg;
        txb_full_next = txb_full_reg;
        rdata_next    = rdata_reg;
        ready_next    = psel_i && !penable_i;
        err_next      = err_reg;
        if (psel_i && !penable_i) begin
            rdata_next = reg_view(paddr_i);
            err_next   = !is_mapped(paddr_i);
        end
        if (wr) begin
            case (paddr_i)
                OFS_CTRL_ONE: c1_next = pwdata_i[C1_WIDTH-1:0];
                OFS_CTRL_THREE: begin
                    // field holds until rewritten
                    tx_ninth_next = pwdata_i[C3_TX_NINTH];
                    tx_dir_next   = pwdata_i[C3_TX_DIR];
                end
                OFS_DATA: begin
                    txb_next      = pwdata_i[7:0];
                    txb_full_next = 1'b1;
                end
                OFS_BAUD:   baud_next = pwdata_i[15:0];
                OFS_STATUS: st_next   = st_reg & ~pwdata_i[ST_WIDTH-1:0];
                OFS_MASK:   mask_next = pwdata_i[ST_WIDTH-1:0];
                default:    st_next   = st_reg;
            endcase
        end
        if (tx_start) begin
            txb_full_next = 1'b0;
        end
        // events set after the clear so a coincident event is kept
        if (run && tx_busy_d_reg && !tx_busy && !txb_full_reg) begin
            st_next[ST_TX_DONE] = 1'b1;
        end
        if (rd_data) begin
            st_next[ST_RX_FULL] = 1'b0;
        end
        if (rx_edge) begin
            st_next[ST_RX_EDGE] = 1'b1;
        end
        if (rx_done && run) begin
            if (!rx_frame_ok) begin
                st_next[ST_FRAMING] = 1'b1;
            end
            if (c1_reg.rx_sleep && c1_reg.addr_wake && rsh_reg[8]) begin
                c1_next.rx_sleep = 1'b0;
            end
        end
        if (rx_done && run && rx_frame_ok && (!c1_reg.rx_sleep || (c1_reg.addr_wake && rsh_reg[8]))) begin
            if (st_reg[ST_RX_FULL] && !rd_data) begin
                st_next[ST_OVERRUN] = 1'b1;
            end else begin
                st_next[ST_RX_FULL] = 1'b1;
            end
        end
        irq_next  = |(st_next & mask_next);
        // wake only from light_stop, gated by the edge mask bit
        wake_next = light_stop_i && st_next[ST_RX_EDGE] && mask_next[ST_RX_EDGE];
    end

    // receiver: sixteen ticks per bit, sample in the middle
    assign rx_done     = (rs_reg == RX_STOP) && tick && (ros_reg == OS_LAST);
    assign rx_frame_ok = rx_in;

    always_comb begin
        rs_next       = rs_reg;
        ros_next      = ros_reg;
        rbit_next     = rbit_reg;
        rsh_next      = rsh_reg;
        rxd_next      = rxd_reg;
        rx_ninth_next = rx_ninth_reg;
        rprev_next    = rx_in;
        if (run) begin
            case (rs_reg)
                RX_IDLE: begin
                    if (c1_reg.rx_enable && !rx_in) begin
                        rs_next  = RX_START;
                        ros_next = 4'h0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        ros_next = ros_reg + 4'h1;
                        if (ros_reg == OS_MID) begin
                            ros_next  = 4'h0;
                            rbit_next = 4'h0;
                            rs_next   = rx_in ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        ros_next = ros_reg + 4'h1;
                        if (ros_reg == OS_LAST) begin
                            rsh_next  = {rx_in, rsh_reg[8:1]};
                            rbit_next = rbit_reg + 4'h1;
                            // the last bit received always lands in bit 8: msb
                            if (rbit_reg == (c1_reg.nine_bit_select ? 4'h8 : 4'h7)) begin
                                rs_next = RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        ros_next = ros_reg + 4'h1;
                        if (ros_reg == OS_LAST) begin
                            rs_next = RX_IDLE;
                            if (rx_frame_ok && (!st_reg[ST_RX_FULL] || rd_data) &&
                                (!c1_reg.rx_sleep || (c1_reg.addr_wake && rsh_reg[8]))) begin
                                rxd_next      = c1_reg.nine_bit_select ? rsh_reg[7:0] : rsh_reg[8:1];
                                rx_ninth_next = c1_reg.nine_bit_select && rsh_reg[8];
                            end
                        end
                    end
                end
                default: rs_next = RX_IDLE;
            endcase
        end
    end

    // pin routing, registered so every pin comes from a flop
    always_comb begin
        txo_next    = tx_line;
        txoe_next   = c1_reg.tx_enable;
        rxused_next = !c1_reg.loop_select;
        if (c1_reg.loop_select && !c1_reg.rx_source_select) begin
            // loop-back keeps the line idle instead of leaking test traffic
            txo_next = 1'b1;
        end else if (c1_reg.loop_select) begin
            txoe_next = tx_dir_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            c1_reg        <= CTRL_ONE_RST;
            tx_ninth_reg  <= 1'b0;
            tx_dir_reg    <= 1'b0;
            baud_reg      <= BAUD_RST;
            st_reg        <= '0;
            mask_reg      <= MASK_RST;
            txb_reg       <= 8'h00;
            txb_full_reg  <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            ready_reg     <= 1'b0;
            err_reg       <= 1'b0;
            irq_reg       <= 1'b0;
            wake_reg      <= 1'b0;
            tx_busy_d_reg <= 1'b0;
            rs_reg        <= RX_IDLE;
            ros_reg       <= 4'h0;
            rbit_reg      <= 4'h0;
            rsh_reg       <= 9'h000;
            rxd_reg       <= 8'h00;
            rx_ninth_reg  <= 1'b0;
            rprev_reg     <= 1'b1;
            txo_reg       <= 1'b1;
            txoe_reg      <= 1'b0;
            rxused_reg    <= 1'b1;
        end else begin
            // bus answers even when frozen; register contents hold except status, which still records a receive edge
            rdata_reg  <= rdata_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
            st_reg     <= st_next;
            irq_reg    <= irq_next;
            wake_reg   <= wake_next;
            rprev_reg  <= rprev_next;
            if (run) begin
                c1_reg        <= c1_next;
                tx_ninth_reg  <= tx_ninth_next;
                tx_dir_reg    <= tx_dir_next;
                baud_reg      <= baud_next;
                mask_reg      <= mask_next;
                txb_reg       <= txb_next;
                txb_full_reg  <= txb_full_next;
                tx_busy_d_reg <= tx_busy;
                rs_reg        <= rs_next;
                ros_reg       <= ros_next;
                rbit_reg      <= rbit_next;
                rsh_reg       <= rsh_next;
                rxd_reg       <= rxd_next;
                rx_ninth_reg  <= rx_ninth_next;
                txo_reg       <= txo_next;
                txoe_reg      <= txoe_next;
                rxused_reg    <= rxused_next;
            end
        end
    end

    assign prdata_o      = rdata_reg;
    assign pready_o      = ready_reg;
    assign pslverr_o     = err_reg && ready_reg;
    assign irq_o         = irq_reg;
    assign wake_o        = wake_reg;
    assign tx_pin_o      = txo_reg;
    assign tx_pin_oe_o   = txoe_reg;
    assign rx_pin_used_o = rxused_reg;
endmodule : unt_top
`default_nettype wire

// ==== unt_top_tb.sv ====
// self-checking bench for the serial transceiver
`timescale 1ns/100ps
`default_nettype none
module unt_top_tb;
    import unt_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        light_stop_i = 1'b0;
    logic        deep_stop_i = 1'b0;
    logic        use_rx = 1'b1;
    logic [31:0] prdata_o, r;
    logic        pready_o, pslverr_o, wake_o, irq_o, tx_pin_o, tx_pin_oe_o, rx_pin_used_o, e;
    logic [8:0]  got;
    wire logic   far_line, tx_pin_i, rx_pin_i;
    int          n_mismatch = 0;
    int          num_checks = 0;
    always #2 clk_i = ~clk_i;
    // released tx wire idles high through its pull-up
    assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : (use_rx ? 1'b1 : far_line);
    assign rx_pin_i = use_rx ? far_line : 1'b1;
    unt_top unt_top_inst (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .light_stop_i, .deep_stop_i, .wake_o, .irq_o, .tx_pin_i, .rx_pin_i, .tx_pin_o,
        .tx_pin_oe_o, .rx_pin_used_o);
    unt_remote unt_remote_inst (.clk_i, .line_i(tx_pin_i), .line_o(far_line));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 16) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, r);
        chk(r, x);
    endtask : rd_chk
    // far side listens while the block sends one character
    task automatic tx_get(input logic [31:0] d);
        bit lost;
        fork
            unt_remote_inst.get(got, 9, lost);
            wr(OFS_DATA, d);
        join
        if (lost) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : tx_get
    task automatic wait_rx;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, r);
            n++;
        end while (r[ST_RX_FULL] !== 1'b1 && n < 300);
        chk(32'(r[ST_RX_FULL]), 32'h1);
        if (r[ST_RX_FULL] !== 1'b1) print_verdict();
    endtask : wait_rx
    task automatic t_reset;
        chk(32'({tx_pin_o, tx_pin_oe_o, rx_pin_used_o, irq_o}), 32'ha);
        rd_chk(8'h40, 32'h0);
        chk(32'(e), 32'h1);
    endtask : t_reset
    // nine-bit loop-back, ninth bit kept for the second character
    task automatic t_loop;
        wr(OFS_CTRL_ONE, 32'h33);
        wr(OFS_CTRL_THREE, 32'h1);
        wr(OFS_DATA, 32'h5a);
        chk(32'(rx_pin_used_o), 32'h0);
        wait_rx;
        rd_chk(OFS_DATA, 32'h5a);
        rd_chk(OFS_CTRL_THREE, 32'h3);
        wr(OFS_DATA, 32'ha5);
        wait_rx;
        rd_chk(OFS_DATA, 32'ha5);
        rd_chk(OFS_CTRL_THREE, 32'h3);
        // sleeping receiver wakes on a ninth bit of one and keeps that character
        wr(OFS_CTRL_ONE, 32'h7b);
        wr(OFS_DATA, 32'h22);
        wait_rx;
        rd_chk(OFS_DATA, 32'h22);
        rd_chk(OFS_CTRL_ONE, 32'h3b);
    endtask : t_loop
    task automatic t_normal;
        wr(OFS_CTRL_ONE, 32'h31);
        tx_get(32'h96);
        chk(32'(got), 32'h196);
        chk(32'(rx_pin_used_o), 32'h1);
        unt_remote_inst.send(9'h0c3, 9);
        wait_rx;
        rd_chk(OFS_DATA, 32'hc3);
        rd_chk(OFS_CTRL_THREE, 32'h1);
    endtask : t_normal
    task automatic t_wire;
        use_rx <= 1'b0;
        wr(OFS_CTRL_THREE, 32'h0);
        wr(OFS_CTRL_ONE, 32'h37);
        // pin flops follow the control register one clock later
        repeat (2) @(posedge clk_i);
        chk(32'({tx_pin_oe_o, rx_pin_used_o}), 32'h0);
        unt_remote_inst.send(9'h155, 9);
        wait_rx;
        rd_chk(OFS_DATA, 32'h55);
        wr(OFS_CTRL_THREE, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(32'(tx_pin_oe_o), 32'h1);
        tx_get(32'h33);
        chk(32'(got), 32'h033);
        wait_rx;
        rd_chk(OFS_DATA, 32'h33);
        use_rx <= 1'b1;
    endtask : t_wire
    // edge while stopped; the line is idle when the stop starts
    task automatic t_edge;
        wr(OFS_CTRL_ONE, 32'h20);
        wr(OFS_STATUS, 32'h1f);
        wr(OFS_MASK, 32'h4);
        chk(32'(irq_o), 32'h0);
        light_stop_i <= 1'b1;
        unt_remote_inst.send(9'h1ff, 8);
        chk(32'({wake_o, irq_o}), 32'h3);
        wr(OFS_MASK, 32'h0);
        light_stop_i <= 1'b0;
        rd_chk(OFS_MASK, 32'h4);
        rd_chk(OFS_STATUS, 32'h4);
        wr(OFS_STATUS, 32'h4);
        rd_chk(OFS_STATUS, 32'h0);
        chk(32'(irq_o), 32'h0);
    endtask : t_edge
    task automatic t_deep;
        deep_stop_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        deep_stop_i <= 1'b0;
        rd_chk(OFS_CTRL_ONE, 32'h0);
        rd_chk(OFS_MASK, 32'h0);
    endtask : t_deep
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_loop();
        t_normal();
        t_wire();
        t_edge();
        t_deep();
        print_verdict();
    end
endmodule : unt_top_tb
`default_nettype wire

// ==== unt_tx.sv ====
// baud tick divider and transmit shifter
`timescale 1ns/100ps
`default_nettype none
module unt_tx (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              run_i,
    // control
    input  wire logic [15:0]       divisor_i,
    input  wire logic              start_i,
    input  wire unt_pkg::unt_char_type char_i,
    // status
    output logic                   tick_o,
    output logic                   line_o,
    output logic                   busy_o
);
    import unt_pkg::*;

    logic [15:0] div_reg, div_next;
    logic [3:0]  os_reg, os_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [10:0] sh_reg, sh_next;
    logic        busy_reg, busy_next;

    // tick is a one-cycle enable at sixteen times the bit rate
    assign tick_o = run_i && (div_reg == divisor_i);
    assign line_o = busy_reg ? sh_reg[0] : 1'b1;
    assign busy_o = busy_reg;

    always_comb begin
        div_next  = div_reg;
        os_next   = os_reg;
        cnt_next  = cnt_reg;
        sh_next   = sh_reg;
        busy_next = busy_reg;
        if (run_i) begin
            div_next = tick_o ? 16'h0000 : div_reg + 16'h0001;
        end
        if (run_i && start_i && !busy_reg) begin
            busy_next = 1'b1;
            os_next   = 4'h0;
            // start, data lsb first, stop; nine-bit frames are one bit longer
            if (char_i.nine) begin
                sh_next  = {1'b1, char_i.bits, 1'b0};
                cnt_next = 4'ha;
            end else begin
                sh_next  = {2'b11, char_i.bits[7:0], 1'b0};
                cnt_next = 4'h9;
            end
        end else if (tick_o && busy_reg) begin
            os_next = os_reg + 4'h1;
            if (os_reg == OS_LAST) begin
                sh_next = {1'b1, sh_reg[10:1]};
                if (cnt_reg == 4'h0) begin
                    busy_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_reg  <= 16'h0000;
            os_reg   <= 4'h0;
            cnt_reg  <= 4'h0;
            sh_reg   <= 11'h7ff;
            busy_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            os_reg   <= os_next;
            cnt_reg  <= cnt_next;
            sh_reg   <= sh_next;
            busy_reg <= busy_next;
        end
    end
endmodule : unt_tx
`default_nettype wire
